/* File: ccp_pkg.sv */
// shared constants for the codec reset, cascade detection and power block
// assumes one 100 MHz master clock shared by every codec and the controller
// Behaviour
// [RL1] decimation overflow sets control 1 bit 7
// [RL2] interpolation overflow sets control 1 bit 4
// [RL3] overflow flags sticky, cleared by reading
// [RL4] controller reads control 1 after power-up
// [RL5] bypass bit skips filters, frame rate x4
// [RL6] bypassed input path decimates only to 4Fs
// [RL7] bypassed output samples arrive pre-interpolated
// [RL8] at most eight codecs while bypassed
// [RL9] divider M multiple of 4 when bypassed
// [RL10] pin or software bit resets everything; the software bit here leaves detection results alone
// [RL11] hardware reset held six clocks minimum
// [RL12] hardware reset after power-up starts detection
// [RL13] cascade detection lasts exactly 132 clocks
// [RL14] controller serial port floats during detection
// [RL15] up to sixteen codecs daisy chained
// [RL16] sync pins swap direction after 64 clocks
// [RL17] two wave counts give position and length
// [RL18] reset synchronous to clock in chains
// [RL19] software power-down per converter, next frame
// [RL20] serial side alive during software power-down; here sdo floats in data frames with the ADC down and data_accept drops with both down
// [RL21] power-down pin low freezes all I/O
// [RL22] power-down pin driven synchronously, tied high
// [RL23] frame traffic ignored until detection completes
// [RL24] control 1 bit 5 selects filter type
package ccp_pkg;
   localparam logic [2:0] CTRL1_ADDR = 3'h1;
   localparam logic [2:0] CTRL2_ADDR = 3'h2;
   localparam logic [2:0] CTRL3_ADDR = 3'h3;
   localparam int CTRL1_DEC_OVF_BIT = 7;
   localparam int CTRL1_FILT_SEL_BIT = 5;
   localparam int CTRL1_INT_OVF_BIT = 4;
   localparam int CTRL2_BYPASS_BIT = 6;
   localparam int CTRL3_ADC_PD_BIT = 7;
   localparam int CTRL3_DAC_PD_BIT = 6;
   localparam int CTRL3_SW_RST_BIT = 5;
   localparam logic [7:0] CTRL1_RESET = 8'h00;
   localparam logic [7:0] CTRL2_RESET = 8'h00;
   localparam logic [7:0] CTRL3_RESET = 8'h00;
   localparam int RESET_HOLD_CYCLES = 6;
   localparam int ACD_CYCLES = 132;
   localparam int ACD_PHASE_CYCLES = 64;
   localparam int MAX_CHAIN = 16;
   localparam int BYPASS_MAX_CHAIN = 8;
   localparam int BYPASS_M_MULT = 4;
   localparam int BYPASS_RATE_MULT = 4;
   localparam int FRAME_CYCLES_DEFAULT = 256;
endpackage : ccp_pkg

/* File: ccp_if.sv */
// link between one codec end and its controller end
// assumes the testbench resolves the two sync pins from the enables
`timescale 1ns/1ps
interface ccp_if;
   logic rst_n;
   logic power_down_pin_n;
   logic fs_i;
   logic fs_o;
   logic fs_oe;
   logic fsd_i;
   logic fsd_o;
   logic fsd_oe;
   logic reg_wr;
   logic reg_rd;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic reg_rvalid;
   modport codec (
      input rst_n,
      input power_down_pin_n,
      input fs_i,
      input fsd_i,
      input reg_wr,
      input reg_rd,
      input reg_addr,
      input reg_wdata,
      output fs_o,
      output fs_oe,
      output fsd_o,
      output fsd_oe,
      output reg_rdata,
      output reg_rvalid
   );
   modport host (
      output rst_n,
      output power_down_pin_n,
      output reg_wr,
      output reg_rd,
      output reg_addr,
      output reg_wdata,
      input reg_rdata,
      input reg_rvalid
   );
endinterface : ccp_if

/* File: ccp_codec_end.sv */
// codec side: reset, cascade detection, power-down, bypass and overflow flags
// assumes control frames are already decoded into reg_wr/reg_rd strobes
`timescale 1ns/1ps
module ccp_codec_end
   import ccp_pkg::*;
#(
   parameter int FRAME_CYCLES = FRAME_CYCLES_DEFAULT
)
(
   input wire logic sys_clk,
   input wire logic reset,
   ccp_if.codec lnk,
   input wire logic dec_ovf_evt,
   input wire logic int_ovf_evt,
   input wire logic data_frame,
   output logic adc_pd,
   output logic dac_pd,
   output logic filter_iir_sel,
   output logic filter_bypass,
   output logic adc_decim_to_4fs,
   output logic frame_tick,
   output logic detect_done,
   output logic [3:0] chain_addr,
   output logic [4:0] chain_total,
   output logic is_master,
   output logic data_accept,
   output logic sdo_float,
   output logic clock_ctrl_en
);
   localparam int FRAME_W = $clog2(FRAME_CYCLES + 1);
   localparam logic [FRAME_W-1:0] FRAME_LAST = FRAME_W'(FRAME_CYCLES - 1);
   localparam logic [FRAME_W-1:0] FRAME_LAST_BYP = FRAME_W'(FRAME_CYCLES / BYPASS_RATE_MULT - 1);
   localparam logic [7:0] ACD_LAST = 8'(ACD_CYCLES - 1);
   localparam logic [7:0] PH1_END = 8'(ACD_PHASE_CYCLES);
   localparam logic [7:0] PH2_END = 8'(2 * ACD_PHASE_CYCLES);

   logic hw_rst;
   logic sw_rst_reg;
   logic core_rst;
   logic awake;
   logic [7:0] acd_cnt_reg;
   logic acd_busy_reg;
   logic ph1;
   logic ph2;
   logic fs_wave_reg;
   logic fsd_wave_reg;
   logic [5:0] cnt1_reg;
   logic seen1_reg;
   logic [5:0] cnt2_reg;
   logic seen2_reg;
   logic last_slave;
   logic done_reg;
   logic [3:0] addr_reg;
   logic [4:0] total_reg;
   logic master_reg;
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   logic [7:0] ctrl3_reg;
   logic dec_ovf_reg;
   logic int_ovf_reg;
   logic wr_ok;
   logic rd_ok;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [FRAME_W-1:0] frm_cnt_reg;
   logic frm_pulse_reg;
   logic fs_in_d_reg;
   logic adc_pd_reg;
   logic dac_pd_reg;

   // hardware reset restarts detection; software reset leaves the address alone
   assign hw_rst = reset | ~lnk.rst_n; // RL10
   assign core_rst = hw_rst | sw_rst_reg; // RL10
   // power-down pin low gates register access, flags and frame count; detection counters still run
   assign awake = lnk.power_down_pin_n; // RL21
   assign ph1 = acd_busy_reg & (acd_cnt_reg < PH1_END);
   assign ph2 = acd_busy_reg & (acd_cnt_reg >= PH1_END) & (acd_cnt_reg < PH2_END);
   assign last_slave = seen1_reg & (cnt1_reg == 6'h00);

   always_ff @(posedge sys_clk)
   begin
      if (hw_rst)
      begin
         acd_cnt_reg <= 8'h00;
         acd_busy_reg <= 1'b1;
      end
      else if (acd_busy_reg)
      begin
         acd_cnt_reg <= acd_cnt_reg + 8'h01; // RL13
         if (acd_cnt_reg == ACD_LAST)
            acd_busy_reg <= 1'b0; // RL13
      end
   end

   // each stage passes the wave one clock further along the chain
   always_ff @(posedge sys_clk)
   begin
      if (hw_rst)
      begin
         fs_wave_reg <= 1'b0;
         fsd_wave_reg <= 1'b1;
      end
      else
      begin
         if (ph1)
            fs_wave_reg <= lnk.fsd_i; // RL16
         if (ph2)
            fsd_wave_reg <= lnk.fs_i; // RL16
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (hw_rst)
      begin
         cnt1_reg <= 6'h3f;
         seen1_reg <= 1'b0;
         cnt2_reg <= 6'h3f;
         seen2_reg <= 1'b0;
      end
      else
      begin
         if (ph1 && !seen1_reg && lnk.fsd_i)
         begin
            cnt1_reg <= acd_cnt_reg[5:0]; // RL17
            seen1_reg <= 1'b1;
         end
         if (ph2 && !seen2_reg && !lnk.fs_i)
         begin
            cnt2_reg <= 6'(acd_cnt_reg - PH1_END); // RL17
            seen2_reg <= 1'b1;
         end
      end
   end

   // a count above fifteen means a broken chain; only the low nibble is kept
   always_ff @(posedge sys_clk)
   begin
      if (hw_rst)
      begin
         done_reg <= 1'b0;
         addr_reg <= 4'h0;
         total_reg <= 5'h01;
         master_reg <= 1'b0;
      end
      else if (acd_busy_reg && acd_cnt_reg == ACD_LAST)
      begin
         done_reg <= 1'b1; // RL23
         addr_reg <= cnt1_reg[3:0]; // RL17
         total_reg <= {1'b0, cnt1_reg[3:0]} + {1'b0, cnt2_reg[3:0]} + 5'h01; // RL15
         master_reg <= seen2_reg & (cnt2_reg == 6'h00);
      end
   end

   // master keeps sync as output; last slave never drives the daisy pin
   assign lnk.fs_oe = awake & (ph1 | (done_reg & master_reg)); // RL16
   assign lnk.fs_o = acd_busy_reg ? fs_wave_reg : frm_pulse_reg;
   assign lnk.fsd_oe = awake & ph2 & ~last_slave; // RL16
   assign lnk.fsd_o = fsd_wave_reg;

   assign wr_ok = lnk.reg_wr & awake & done_reg & ~acd_busy_reg; // RL23
   assign rd_ok = lnk.reg_rd & awake & done_reg & ~acd_busy_reg; // RL23

   always_ff @(posedge sys_clk)
   begin
      if (hw_rst)
         sw_rst_reg <= 1'b0;
      else
         sw_rst_reg <= wr_ok & (lnk.reg_addr == CTRL3_ADDR) & lnk.reg_wdata[CTRL3_SW_RST_BIT]; // RL10
   end

   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
      begin
         ctrl1_reg <= CTRL1_RESET; // RL10
         ctrl2_reg <= CTRL2_RESET;
         ctrl3_reg <= CTRL3_RESET;
      end
      else if (wr_ok)
      begin
         if (lnk.reg_addr == CTRL1_ADDR)
            ctrl1_reg <= lnk.reg_wdata;
         else if (lnk.reg_addr == CTRL2_ADDR)
            ctrl2_reg <= lnk.reg_wdata;
         else if (lnk.reg_addr == CTRL3_ADDR)
            ctrl3_reg <= lnk.reg_wdata & ~(8'h01 << CTRL3_SW_RST_BIT);
      end
   end

   // an overflow in the same cycle as the clearing read survives it
   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
      begin
         dec_ovf_reg <= 1'b0;
         int_ovf_reg <= 1'b0;
      end
      else if (awake)
      begin
         if (dec_ovf_evt)
            dec_ovf_reg <= 1'b1; // RL1
         else if (rd_ok && lnk.reg_addr == CTRL1_ADDR)
            dec_ovf_reg <= 1'b0; // RL3
         if (int_ovf_evt)
            int_ovf_reg <= 1'b1; // RL2
         else if (rd_ok && lnk.reg_addr == CTRL1_ADDR)
            int_ovf_reg <= 1'b0; // RL3
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
      begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         rvalid_reg <= rd_ok;
         if (rd_ok)
         begin
            if (lnk.reg_addr == CTRL1_ADDR)
            begin
               rdata_reg <= ctrl1_reg;
               rdata_reg[CTRL1_DEC_OVF_BIT] <= dec_ovf_reg; // RL1
               rdata_reg[CTRL1_INT_OVF_BIT] <= int_ovf_reg; // RL2
            end
            else if (lnk.reg_addr == CTRL2_ADDR)
               rdata_reg <= ctrl2_reg;
            else if (lnk.reg_addr == CTRL3_ADDR)
               rdata_reg <= ctrl3_reg;
            else
               rdata_reg <= 8'h00;
         end
      end
   end
   assign lnk.reg_rdata = rdata_reg;
   assign lnk.reg_rvalid = rvalid_reg;

   // bypass shortens the frame period by four
   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
      begin
         frm_cnt_reg <= '0;
         frm_pulse_reg <= 1'b0;
      end
      else if (awake && done_reg && master_reg)
      begin
         if (frm_cnt_reg >= (ctrl2_reg[CTRL2_BYPASS_BIT] ? FRAME_LAST_BYP : FRAME_LAST)) // RL5
         begin
            frm_cnt_reg <= '0;
            frm_pulse_reg <= 1'b1;
         end
         else
         begin
            frm_cnt_reg <= frm_cnt_reg + 1'b1;
            frm_pulse_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
         fs_in_d_reg <= 1'b0;
      else
         fs_in_d_reg <= lnk.fs_i;
   end
   assign frame_tick = done_reg & awake &
      (master_reg ? frm_pulse_reg : (lnk.fs_i & ~fs_in_d_reg));

   // power-down bits only act on a frame boundary
   always_ff @(posedge sys_clk)
   begin
      if (core_rst)
      begin
         adc_pd_reg <= 1'b0;
         dac_pd_reg <= 1'b0;
      end
      else if (frame_tick)
      begin
         adc_pd_reg <= ctrl3_reg[CTRL3_ADC_PD_BIT]; // RL19
         dac_pd_reg <= ctrl3_reg[CTRL3_DAC_PD_BIT]; // RL19
      end
   end

   assign adc_pd = adc_pd_reg | ~awake;
   assign dac_pd = dac_pd_reg | ~awake;
   assign filter_iir_sel = ctrl1_reg[CTRL1_FILT_SEL_BIT]; // RL24
   assign filter_bypass = ctrl2_reg[CTRL2_BYPASS_BIT]; // RL5
   assign adc_decim_to_4fs = ctrl2_reg[CTRL2_BYPASS_BIT]; // RL6
   assign detect_done = done_reg;
   assign chain_addr = addr_reg;
   assign chain_total = total_reg;
   assign is_master = master_reg;
   assign data_accept = awake & done_reg & data_frame & ~(adc_pd_reg & dac_pd_reg); // RL20
   assign sdo_float = ~awake | ~done_reg | (data_frame & adc_pd_reg); // RL20
   assign clock_ctrl_en = awake; // RL21
endmodule : ccp_codec_end

/* File: ccp_host_end.sv */
// controller side: power-up reset, detection wait, flag clear, power-down pin
// assumes the controller's serial port follows serial_port_en
`timescale 1ns/1ps
module ccp_host_end
   import ccp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   ccp_if.host lnk,
   input wire logic pd_req,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   input wire logic [2:0] cmd_addr,
   input wire logic [7:0] cmd_wdata,
   input wire logic [4:0] chain_len,
   input wire logic [6:0] m_div,
   output logic cmd_ready,
   output logic cmd_refused,
   output logic rd_valid,
   output logic [7:0] rd_data,
   output logic serial_port_en,
   output logic init_done
);
   typedef enum logic [1:0] {
      CCP_H_RESET = 2'b00,
      CCP_H_ACD = 2'b01,
      CCP_H_CLEAR = 2'b10,
      CCP_H_IDLE = 2'b11
   } ccp_hstate_t;

   localparam logic [7:0] HOLD_LAST = 8'(RESET_HOLD_CYCLES - 1);
   localparam logic [7:0] ACD_LAST = 8'(ACD_CYCLES - 1);

   ccp_hstate_t state_reg;
   logic [7:0] cnt_reg;
   logic rst_n_reg;
   logic pd_n_reg;
   logic wr_reg;
   logic rd_reg;
   logic [2:0] addr_reg;
   logic [7:0] wdata_reg;
   logic refused_reg;
   logic [7:0] rd_data_reg;
   logic rd_valid_reg;
   logic [1:0] clr_pipe_reg;
   logic bypass_bad;

   // bypass needs a short chain and a divider that is a multiple of four
   assign bypass_bad = cmd_wdata[CTRL2_BYPASS_BIT] &
      ((chain_len > 5'(BYPASS_MAX_CHAIN)) || (m_div % 7'(BYPASS_M_MULT) != 7'h00)); // RL8 RL9

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_reg <= CCP_H_RESET;
         cnt_reg <= 8'h00;
         rst_n_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            CCP_H_RESET:
            begin
               rst_n_reg <= 1'b0; // RL12
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == HOLD_LAST) // RL11
               begin
                  rst_n_reg <= 1'b1; // RL18
                  cnt_reg <= 8'h00;
                  state_reg <= CCP_H_ACD;
               end
            end
            CCP_H_ACD:
            begin
               cnt_reg <= cnt_reg + 8'h01;
               if (cnt_reg == ACD_LAST) // RL14
                  state_reg <= CCP_H_CLEAR;
            end
            CCP_H_CLEAR:
               state_reg <= CCP_H_IDLE;
            default:
               state_reg <= CCP_H_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         addr_reg <= 3'h0;
         wdata_reg <= 8'h00;
         refused_reg <= 1'b0;
      end
      else
      begin
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         refused_reg <= 1'b0;
         if (state_reg == CCP_H_CLEAR)
         begin
            rd_reg <= 1'b1; // RL4
            addr_reg <= CTRL1_ADDR; // RL4
         end
         else if (state_reg == CCP_H_IDLE && cmd_wr)
         begin
            if (cmd_addr == CTRL2_ADDR && bypass_bad)
               refused_reg <= 1'b1; // RL8 RL9
            else
            begin
               wr_reg <= 1'b1;
               addr_reg <= cmd_addr;
               wdata_reg <= cmd_wdata;
            end
         end
         else if (state_reg == CCP_H_IDLE && cmd_rd)
         begin
            rd_reg <= 1'b1;
            addr_reg <= cmd_addr;
         end
      end
   end

   // registered so the release lands on a clock edge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         pd_n_reg <= 1'b1;
      else
         pd_n_reg <= ~pd_req; // RL22
   end

   // the clearing read during init is not reported to the user
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rd_data_reg <= 8'h00;
         rd_valid_reg <= 1'b0;
         clr_pipe_reg <= 2'h0;
      end
      else
      begin
         // answer to the clearing read lands two edges after CLEAR, already in idle
         clr_pipe_reg <= {clr_pipe_reg[0], state_reg == CCP_H_CLEAR};
         rd_valid_reg <= lnk.reg_rvalid & init_done & ~clr_pipe_reg[1]; // RL4
         if (lnk.reg_rvalid)
            rd_data_reg <= lnk.reg_rdata;
      end
   end

   assign lnk.rst_n = rst_n_reg;
   assign lnk.power_down_pin_n = pd_n_reg;
   assign lnk.reg_wr = wr_reg;
   assign lnk.reg_rd = rd_reg;
   assign lnk.reg_addr = addr_reg;
   assign lnk.reg_wdata = wdata_reg;
   assign init_done = (state_reg == CCP_H_IDLE);
   assign cmd_ready = init_done;
   assign cmd_refused = refused_reg;
   assign rd_valid = rd_valid_reg;
   assign rd_data = rd_data_reg;
   assign serial_port_en = (state_reg == CCP_H_CLEAR) | init_done; // RL14
endmodule : ccp_host_end

/* File: ccp_link_checker.sv */
// checker: timing relations on the codec/controller link
// assumes one clock, synchronous active-high reset, a single-codec chain
`timescale 1ns/1ps
module ccp_link_checker
   import ccp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic rst_n,
   input wire logic power_down_pin_n,
   input wire logic fs_o,
   input wire logic fs_oe,
   input wire logic fsd_i,
   input wire logic fsd_oe,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [2:0] reg_addr,
   input wire logic reg_rvalid
);
   logic [7:0] k_reg;
   // preset so a pin still unknown before the first edge cannot poison the count
   logic [3:0] low_reg = 4'h0;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   // edges since the reset pin went high, saturating
   always_ff @(posedge sys_clk)
      if (reset || !rst_n)
         k_reg <= 8'h00;
      else if (k_reg != 8'hff)
         k_reg <= k_reg + 8'h01;

   always_ff @(posedge sys_clk)
      if (rst_n == 1'b1)
         low_reg <= 4'h0;
      else if (low_reg != 4'hf)
         low_reg <= low_reg + 4'h1;

   a_hold_six: assert property ($rose(rst_n) |-> low_reg >= 4'h6)
      else $error("reset pin released too early");
   a_host_quiet: assert property (rst_n && k_reg < 8'h84 |-> !reg_rd && !reg_wr)
      else $error("controller strobed during detection");
   a_clear_read: assert property ($rose(rst_n) |-> ##[132:160] (reg_rd && reg_addr == CTRL1_ADDR))
      else $error("no flag clearing read after detection");
   a_fs_drive_p1: assert property (rst_n && k_reg inside {[8'h02:8'h3e]} |-> fs_oe && fs_o == $past(fsd_i))
      else $error("frame sync not relaying daisy input in phase one");
   a_fs_input_p2: assert property (rst_n && k_reg inside {[8'h42:8'h7e]} |-> !fs_oe)
      else $error("frame sync driven in phase two");
   a_detect_len: assert property ($rose(rst_n) && power_down_pin_n |-> ##131 !fs_oe ##1 fs_oe)
      else $error("detection did not last exactly 132 clocks");
   a_master_fs: assert property (rst_n && power_down_pin_n && k_reg inside {[8'h86:8'hc8]} |-> fs_oe)
      else $error("master not driving frame sync after detection");
   a_last_fsd_in: assert property (rst_n |-> !fsd_oe)
      else $error("last codec drove its daisy pin");
   a_read_answer: assert property (reg_rd && rst_n && power_down_pin_n && k_reg >= 8'h86 |=> reg_rvalid)
      else $error("read not answered next cycle");
   a_pd_silent: assert property (!power_down_pin_n |=> !reg_rvalid)
      else $error("answer given in hardware power-down");
endmodule : ccp_link_checker

/* File: codec_reset_cascade_power_tb_top.sv */
// testbench: controller end and one codec end joined by the link interface
// assumes a lone codec: its frame sync pulled low and daisy pin pulled high
`timescale 1ns/1ps
module codec_reset_cascade_power_tb_top;
   import ccp_pkg::*;
   logic sys_clk = 1'b0, reset = 1'b1;
   logic dec_ovf_evt = 1'b0, int_ovf_evt = 1'b0, data_frame = 1'b1, pd_req = 1'b0;
   logic cmd_wr = 1'b0, cmd_rd = 1'b0, refused;
   logic [2:0] cmd_addr = 3'h0;
   logic [7:0] cmd_wdata = 8'h00;
   logic [4:0] chain_len = 5'h01;
   logic [6:0] m_div = 7'h08;
   logic adc_pd, dac_pd, filter_iir_sel, filter_bypass, adc_decim_to_4fs, frame_tick;
   logic detect_done, is_master, data_accept, sdo_float, clock_ctrl_en;
   logic cmd_ready, cmd_refused, rd_valid, serial_port_en, init_done;
   logic [3:0] chain_addr;
   logic [4:0] chain_total;
   logic [7:0] rd_data;
   int err_total = 0, checked = 0, n;

   ccp_if lnk();
   // undriven pins fall to their pull levels
   assign lnk.fs_i = lnk.fs_oe ? lnk.fs_o : 1'b0;
   assign lnk.fsd_i = lnk.fsd_oe ? lnk.fsd_o : 1'b1;

   always #5 sys_clk = ~sys_clk;

   ccp_codec_end #(.FRAME_CYCLES(16)) u_ccp_codec_end (.sys_clk(sys_clk), .reset(reset),
      .lnk(lnk), .dec_ovf_evt(dec_ovf_evt), .int_ovf_evt(int_ovf_evt), .data_frame(data_frame),
      .adc_pd(adc_pd), .dac_pd(dac_pd), .filter_iir_sel(filter_iir_sel),
      .filter_bypass(filter_bypass), .adc_decim_to_4fs(adc_decim_to_4fs),
      .frame_tick(frame_tick), .detect_done(detect_done), .chain_addr(chain_addr),
      .chain_total(chain_total), .is_master(is_master), .data_accept(data_accept),
      .sdo_float(sdo_float), .clock_ctrl_en(clock_ctrl_en));

   ccp_host_end u_ccp_host_end (.sys_clk(sys_clk), .reset(reset), .lnk(lnk), .pd_req(pd_req),
      .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
      .chain_len(chain_len), .m_div(m_div), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
      .rd_valid(rd_valid), .rd_data(rd_data), .serial_port_en(serial_port_en),
      .init_done(init_done));

   ccp_link_checker u_ccp_link_checker (.sys_clk(sys_clk), .reset(reset), .rst_n(lnk.rst_n),
      .power_down_pin_n(lnk.power_down_pin_n), .fs_o(lnk.fs_o), .fs_oe(lnk.fs_oe),
      .fsd_i(lnk.fsd_i), .fsd_oe(lnk.fsd_oe), .reg_wr(lnk.reg_wr), .reg_rd(lnk.reg_rd),
      .reg_addr(lnk.reg_addr), .reg_rvalid(lnk.reg_rvalid));

   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : chk

   task step(input int c);
      repeat (c) @(posedge sys_clk);
      #1;
   endtask : step

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      cmd_wr <= 1'b1;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge sys_clk);
      cmd_wr <= 1'b0;
      #1;
      refused = cmd_refused;
      step(1);
      refused = refused | cmd_refused;
      step(1);
   endtask : wr

   task rd(input logic [2:0] a, input logic [7:0] exp);
      int i;
      @(posedge sys_clk);
      cmd_rd <= 1'b1;
      cmd_addr <= a;
      @(posedge sys_clk);
      cmd_rd <= 1'b0;
      for (i = 0; i < 6; i++)
      begin
         #1;
         if (rd_valid === 1'b1)
            break;
         @(posedge sys_clk);
      end
      if (rd_valid !== 1'b1)
         chk({7'h00, rd_valid}, 8'h01);
      else
         chk(rd_data, exp);
   endtask : rd

   // cycles until the next frame tick
   task tick(output int c);
      c = 0;
      do
      begin
         step(1);
         c++;
      end
      while (frame_tick !== 1'b1 && c < 64);
   endtask : tick

   task finish_test;
      $display("%0d comparisons, %0d mismatches", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : finish_test

   initial
   begin
      repeat (5000) @(posedge sys_clk);
      err_total++;
      finish_test();
   end

   initial
   begin
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      step(50);
      chk({6'h00, detect_done, data_accept}, 8'h00);
      chk({7'h00, serial_port_en}, 8'h00);
      for (n = 0; n < 300 && init_done !== 1'b1; n++)
         step(1);
      chk({5'h00, init_done, cmd_ready, serial_port_en}, 8'h07);
      chk({3'h0, detect_done, chain_addr}, 8'h10);
      chk({2'h0, is_master, chain_total}, 8'h21);
      chk({7'h00, data_accept}, 8'h01);
      step(2);
      chk({7'h00, rd_valid}, 8'h00);
      rd(CTRL1_ADDR, 8'h00);
      $display("test detection finished");
      @(posedge sys_clk);
      dec_ovf_evt <= 1'b1;
      @(posedge sys_clk);
      dec_ovf_evt <= 1'b0;
      rd(CTRL1_ADDR, 8'h80);
      rd(CTRL1_ADDR, 8'h00);
      wr(CTRL1_ADDR, 8'h20);
      chk({7'h00, filter_iir_sel}, 8'h01);
      @(posedge sys_clk);
      int_ovf_evt <= 1'b1;
      @(posedge sys_clk);
      int_ovf_evt <= 1'b0;
      rd(CTRL1_ADDR, 8'h30);
      rd(CTRL1_ADDR, 8'h20);
      rd(3'h5, 8'h00);
      $display("test overflow finished");
      tick(n);
      tick(n);
      chk(n[7:0], 8'h10);
      @(posedge sys_clk);
      chain_len <= 5'h09;
      wr(CTRL2_ADDR, 8'h40);
      chk({6'h00, refused, filter_bypass}, 8'h02);
      @(posedge sys_clk);
      chain_len <= 5'h08;
      m_div <= 7'h06;
      wr(CTRL2_ADDR, 8'h40);
      chk({6'h00, refused, filter_bypass}, 8'h02);
      @(posedge sys_clk);
      m_div <= 7'h08;
      wr(CTRL2_ADDR, 8'h40);
      chk({6'h00, refused, filter_bypass}, 8'h01);
      chk({6'h00, filter_bypass, adc_decim_to_4fs}, 8'h03);
      tick(n);
      tick(n);
      chk(n[7:0], 8'h04);
      $display("test bypass finished");
      wr(CTRL3_ADDR, 8'hc0);
      tick(n);
      step(1);
      chk({6'h00, adc_pd, dac_pd}, 8'h03);
      chk({6'h00, data_accept, sdo_float}, 8'h01);
      @(posedge sys_clk);
      data_frame <= 1'b0;
      step(1);
      chk({6'h00, data_accept, sdo_float}, 8'h00);
      @(posedge sys_clk);
      data_frame <= 1'b1;
      rd(CTRL1_ADDR, 8'h20);
      wr(CTRL3_ADDR, 8'h80);
      tick(n);
      step(1);
      chk({5'h00, adc_pd, dac_pd, data_accept}, 8'h05);
      wr(CTRL3_ADDR, 8'h00);
      tick(n);
      step(1);
      chk({6'h00, adc_pd, dac_pd}, 8'h00);
      @(posedge sys_clk);
      pd_req <= 1'b1;
      step(3);
      chk({4'h0, clock_ctrl_en, adc_pd, data_accept, sdo_float}, 8'h05);
      @(posedge sys_clk);
      pd_req <= 1'b0;
      step(3);
      chk({7'h00, clock_ctrl_en}, 8'h01);
      rd(CTRL2_ADDR, 8'h40);
      $display("test power finished");
      wr(CTRL3_ADDR, 8'h20);
      rd(CTRL1_ADDR, 8'h00);
      rd(CTRL2_ADDR, 8'h00);
      rd(CTRL3_ADDR, 8'h00);
      chk({6'h00, detect_done, filter_bypass}, 8'h02);
      $display("test reset finished");
      finish_test();
   end
endmodule : codec_reset_cascade_power_tb_top
